// *** hw/swie_entry.v ***
// Purpose: sleep exit and interrupt entry sequencing for the CPU
// Assumes: CPU flags fetch/execute/commit of the sleep op; bus acks 1 cycle
// Notes:   entry pushes PC then flags, then reads a two-word vector
`timescale 1ns/100ps
`include "swie_map.vh"

module swie_entry (
   input  wire                     i_sys_clk,
   input  wire                     i_sys_rst,
   input  wire                     i_ce,
   input  wire                     i_irq,
   input  wire                     i_prev_done,
   input  wire                     i_slp_fetch,
   input  wire                     i_slp_exec,
   input  wire                     i_slp_commit,
   input  wire [`SWIE_AW-1:0]      i_slp_pc,
   input  wire [`SWIE_AW-1:0]      i_next_pc,
   input  wire [`SWIE_AW-1:0]      i_sp,
   input  wire [`SWIE_FLG_W-1:0]   i_condition_flags_register,
   input  wire [`SWIE_AW-1:0]      i_vec_addr,
   input  wire                     i_bus_ack,
   input  wire [`SWIE_DW-1:0]      i_bus_rdata,
   output wire                     o_sleeping,
   output wire                     o_slp_abort,
   output wire                     o_bus_req,
   output wire                     o_bus_we,
   output reg  [`SWIE_AW-1:0]      o_bus_addr,
   output reg  [`SWIE_DW-1:0]      o_bus_wdata,
   output reg  [`SWIE_AW-1:0]      o_ret_pc,
   output reg  [`SWIE_AW-1:0]      o_handler_pc,
   output reg                      o_handler_valid
);

   // One-hot states
   localparam [8:0] ST_IDLE  = 9'h001;
   localparam [8:0] ST_PEND  = 9'h002;
   localparam [8:0] ST_SLEEP = 9'h004;
   localparam [8:0] ST_WAKE  = 9'h008;
   localparam [8:0] ST_PC    = 9'h010;
   localparam [8:0] ST_FLG   = 9'h020;
   localparam [8:0] ST_VHI   = 9'h040;
   localparam [8:0] ST_VLO   = 9'h080;
   localparam [8:0] ST_GO    = 9'h100;

   // Address below a base, used for both stack slots
   function [`SWIE_AW-1:0] sub_ofs;
      input [`SWIE_AW-1:0] base;
      input [`SWIE_AW-1:0] ofs;
      begin
         sub_ofs = base - ofs;
      end
   endfunction

   reg  [8:0]               state_reg;
   reg  [8:0]               state_next;
   reg                      irq_fall_reg;
   reg                      irq_sync_reg;
   reg  [`SWIE_AW-1:0]      ret_next;
   reg  [`SWIE_AW-1:0]      sp_reg;
   reg  [`SWIE_AW-1:0]      sp_next;
   reg  [`SWIE_FLG_W-1:0]   flg_reg;
   reg  [`SWIE_FLG_W-1:0]   flg_next;
   reg  [`SWIE_AW-1:0]      addr_next;
   reg  [`SWIE_DW-1:0]      wdata_next;
   reg  [`SWIE_AW-1:0]      hpc_next;
   reg                      hvalid_next;
   reg                      wake_start;
   wire                     wake_done;

   // fall sample
   // First stage takes the pin on the falling edge, the second re-times it
   always @(negedge i_sys_clk) begin
      if (i_sys_rst) begin
         irq_fall_reg <= 1'b0;
      end else if (i_ce) begin
         irq_fall_reg <= i_irq;
      end
   end

   // Second stage; only this one is read by logic
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         irq_sync_reg <= 1'b0;
      end else if (i_ce) begin
         irq_sync_reg <= irq_fall_reg;
      end
   end

   swie_delay u_wake (
      .i_sys_clk (i_sys_clk),
      .i_sys_rst (i_sys_rst),
      .i_ce      (i_ce),
      .i_start   (wake_start),
      .o_done    (wake_done)
   );

   // Status and bus handshake, decoded straight from the state
   assign o_sleeping  = state_reg[2] | state_reg[3];
   assign o_slp_abort = state_reg[1];
   assign o_bus_req   = state_reg[4] | state_reg[5] | state_reg[6]
                        | state_reg[7];
   assign o_bus_we    = state_reg[4] | state_reg[5];

   // Next-state and datapath decode
   always @* begin
      state_next  = state_reg;
      ret_next    = o_ret_pc;
      sp_next     = sp_reg;
      flg_next    = flg_reg;
      addr_next   = o_bus_addr;
      wdata_next  = o_bus_wdata;
      hpc_next    = o_handler_pc;
      hvalid_next = 1'b0;
      wake_start  = 1'b0;
      case (state_reg)
         ST_IDLE: begin
            // commit point
            // Request seen before commit wins; commit alone means sleep
            if (irq_sync_reg && i_slp_exec) begin
               // no sleep
               // Entry straight from execution, resume after the sleep op
               ret_next   = i_next_pc;
               sp_next    = i_sp;
               flg_next   = i_condition_flags_register;
               state_next = ST_PC;
            end else if (irq_sync_reg && i_slp_fetch) begin
               // fetch case
               // Sleep op is dropped and re-run after the handler
               ret_next = i_slp_pc;
               if (i_prev_done) begin
                  sp_next    = i_sp;
                  flg_next   = i_condition_flags_register;
                  state_next = ST_PC;
               end else begin
                  state_next = ST_PEND;
               end
            end else if (i_slp_commit) begin
               ret_next   = i_next_pc;
               state_next = ST_SLEEP;
            end else if (irq_sync_reg && i_prev_done) begin
               // Ordinary boundary entry outside the sleep sequence
               ret_next   = i_next_pc;
               sp_next    = i_sp;
               flg_next   = i_condition_flags_register;
               state_next = ST_PC;
            end
         end
         ST_PEND: begin
            // wait prior op
            // Return address stays the sleep op while the prior op ends
            if (i_prev_done) begin
               sp_next    = i_sp;
               flg_next   = i_condition_flags_register;
               state_next = ST_PC;
            end
         end
         ST_SLEEP: begin
            // cancel sleep
            // Sampled request starts the delay; sleep still shows meanwhile
            if (irq_sync_reg) begin
               wake_start = 1'b1;
               state_next = ST_WAKE;
            end
         end
         ST_WAKE: begin
            if (wake_done) begin
               sp_next    = i_sp;
               flg_next   = i_condition_flags_register;
               state_next = ST_PC;
            end
         end
         ST_PC: begin
            addr_next  = sub_ofs(sp_reg, `SWIE_SP_PC_OFS);
            wdata_next = o_ret_pc[`SWIE_DW-1:0];
            if (i_bus_ack) begin
               state_next = ST_FLG;
            end
         end
         ST_FLG: begin
            // push flags
            // Flags share the word with the PC top byte
            addr_next  = sub_ofs(sp_reg, `SWIE_SP_FLG_OFS);
            wdata_next = {flg_reg, o_ret_pc[`SWIE_AW-1:`SWIE_DW]};
            if (i_bus_ack) begin
               state_next = ST_VHI;
            end
         end
         ST_VHI: begin
            addr_next = i_vec_addr;
            if (i_bus_ack) begin
               hpc_next[`SWIE_AW-1:`SWIE_DW] =
                  i_bus_rdata[`SWIE_AW-`SWIE_DW-1:0];
               state_next = ST_VLO;
            end
         end
         ST_VLO: begin
            addr_next = i_vec_addr + `SWIE_VEC_LO_OFS;
            if (i_bus_ack) begin
               hpc_next[`SWIE_DW-1:0] = i_bus_rdata;
               state_next = ST_GO;
            end
         end
         ST_GO: begin
            // Handler address handed to the fetch unit for one cycle
            hvalid_next = 1'b1;
            state_next  = ST_IDLE;
         end
         default: begin
            state_next = ST_IDLE;
         end
      endcase
   end

   // State and datapath registers; all frozen while i_ce is low
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         state_reg       <= ST_IDLE;
         o_ret_pc        <= `SWIE_ADDR_RST;
         sp_reg          <= `SWIE_ADDR_RST;
         flg_reg         <= {`SWIE_FLG_W{1'b0}};
         o_bus_addr      <= `SWIE_ADDR_RST;
         o_bus_wdata     <= `SWIE_DATA_RST;
         o_handler_pc    <= `SWIE_ADDR_RST;
         o_handler_valid <= 1'b0;
      end else if (i_ce) begin
         state_reg       <= state_next;
         o_ret_pc        <= ret_next;
         sp_reg          <= sp_next;
         flg_reg         <= flg_next;
         o_bus_addr      <= addr_next;
         o_bus_wdata     <= wdata_next;
         o_handler_pc    <= hpc_next;
         o_handler_valid <= hvalid_next;
      end
   end

endmodule // swie_entry

// *** include/swie_map.vh ***
// Purpose: constants for the sleep wake-up and interrupt entry block
// Assumes: one state of the system clock equals one i_sys_clk cycle
// Notes:   addresses are 24 bits, bus data is 16 bits
`ifndef SWIE_MAP_VH
`define SWIE_MAP_VH

// Bus and field widths
`define SWIE_AW          24
`define SWIE_DW          16
`define SWIE_FLG_W       8

// Wake delay: time in states and the matching cycle count (1 state = 1 clk)
`define SWIE_WAKE_STATES 6
`define SWIE_WAKE_CYC    (`SWIE_WAKE_STATES * 1)
`define SWIE_CNT_W       3

// Stack offsets below SP for the two saved words
`define SWIE_SP_PC_OFS   24'h000002
`define SWIE_SP_FLG_OFS  24'h000004
// Second vector word sits one word above the first
`define SWIE_VEC_LO_OFS  24'h000002

// Reset values
`define SWIE_ADDR_RST    24'h000000
`define SWIE_DATA_RST    16'h0000

`endif

// *** hw/swie_delay.v ***
// Purpose: counts the fixed wake delay after a sampled request
// Assumes: i_start is a one-cycle pulse from the same clock
// Notes:   a new start while running restarts the count
`timescale 1ns/100ps
`include "swie_map.vh"

module swie_delay (
   input  wire i_sys_clk,
   input  wire i_sys_rst,
   input  wire i_ce,
   input  wire i_start,
   output wire o_done
);

   // Count is narrowed on purpose; six fits in the counter width
   localparam integer           LOAD_INT = `SWIE_WAKE_CYC;
   localparam [`SWIE_CNT_W-1:0] LOAD_VAL = LOAD_INT[`SWIE_CNT_W-1:0];

   reg  [`SWIE_CNT_W-1:0] cnt_reg;
   reg  [`SWIE_CNT_W-1:0] cnt_next;

   // Done in the cycle the count reaches one, i.e. N cycles after start
   assign o_done = (cnt_reg == {{(`SWIE_CNT_W-1){1'b0}}, 1'b1});

   // Reload on start, else count down to zero and hold
   always @* begin
      cnt_next = cnt_reg;
      if (i_start) begin
         cnt_next = LOAD_VAL;
      end else if (cnt_reg != {`SWIE_CNT_W{1'b0}}) begin
         cnt_next = cnt_reg - {{(`SWIE_CNT_W-1){1'b0}}, 1'b1};
      end
   end

   // Counter flop
   always @(posedge i_sys_clk) begin
      if (i_sys_rst) begin
         cnt_reg <= {`SWIE_CNT_W{1'b0}};
      end else if (i_ce) begin
         cnt_reg <= cnt_next;
      end
   end

endmodule // swie_delay

// *** verification/swie_mem.sv ***
// Purpose: memory bus partner holding stack and vector words
// Assumes: one request at a time, level until acknowledged
// Notes:   acks only once the design's address has settled
`timescale 1ns/100ps
module swie_mem (
   input  wire        i_clk,
   input  wire        i_rst,
   input  wire        i_req,
   input  wire        i_we,
   input  wire        i_slow,
   input  wire [23:0] i_addr,
   input  wire [15:0] i_wdata,
   output reg         o_ack,
   output reg  [15:0] o_rdata
);
   logic   [15:0] mem [int];
   integer        w;
   // Read data toggles outside acks so stale values never look valid
   always @(posedge i_clk) begin
      o_ack <= 1'b0;
      o_rdata <= ~o_rdata;
      if (i_rst) begin
         w <= 0;
         o_rdata <= 16'h0000;
      end else if (i_req && !o_ack) begin
         if (w >= (i_slow ? 3 : 1)) begin
            o_ack <= 1'b1;
            w <= 0;
            if (i_we) mem[i_addr] = i_wdata;
            else o_rdata <= mem[i_addr];
         end else w <= w + 1;
      end
   end
endmodule // swie_mem

// *** verification/swie_entry_properties.sv ***
// Purpose: timing and order checks on sleep exit and entry
// Assumes: i_ce held high
// Notes:   request mirror may lag the design's sampler by one edge
`timescale 1ns/100ps
`include "swie_map.vh"
module swie_entry_chk (
   input wire                i_sys_clk,
   input wire                i_sys_rst,
   input wire                i_irq,
   input wire                i_prev_done,
   input wire [`SWIE_AW-1:0] i_sp,
   input wire [`SWIE_AW-1:0] i_vec_addr,
   input wire                i_bus_ack,
   input wire                o_sleeping,
   input wire                o_slp_abort,
   input wire                o_bus_req,
   input wire                o_bus_we,
   input wire [`SWIE_AW-1:0] o_bus_addr,
   input wire                o_handler_valid
);
   reg       irq_f;
   reg [3:0] cnt;
   // Falling-edge mirror of request sampling and wake counter
   always @(negedge i_sys_clk) irq_f <= i_irq;
   always @(posedge i_sys_clk)
      if (i_sys_rst || !o_sleeping) cnt <= 4'h0;
      else if (irq_f || cnt != 4'h0) cnt <= cnt + 4'h1;
   default clocking @(posedge i_sys_clk); endclocking
   default disable iff (i_sys_rst);
   property p_wake; $fell(o_sleeping) |-> cnt inside {4'h7, 4'h8};
   endproperty
   a_wake: assert property (p_wake) else $error("wake delay off");
   property p_cancel; $fell(o_sleeping) |-> o_bus_req && o_bus_we;
   endproperty
   a_cancel: assert property (p_cancel) else $error("no entry");
   property p_push1;
      $rose(o_bus_req) |=> o_bus_we && o_bus_addr == i_sp - 24'h2;
   endproperty
   a_push1: assert property (p_push1) else $error("push pc");
   property p_push2; i_bus_ack && o_bus_we && o_bus_addr == i_sp - 24'h2
      |-> ##2 o_bus_we && o_bus_addr == i_sp - 24'h4;
   endproperty
   a_push2: assert property (p_push2) else $error("push flags");
   property p_vec1; i_bus_ack && o_bus_we && o_bus_addr == i_sp - 24'h4
      |-> ##2 !o_bus_we && o_bus_req && o_bus_addr == i_vec_addr;
   endproperty
   a_vec1: assert property (p_vec1) else $error("vector read");
   property p_vec2; i_bus_ack && !o_bus_we && o_bus_addr == i_vec_addr
      |-> ##2 o_bus_addr == i_vec_addr + 24'h2;
   endproperty
   a_vec2: assert property (p_vec2) else $error("vector word 2");
   property p_go; i_bus_ack && o_bus_addr == i_vec_addr + 24'h2
      |-> ##1 !o_bus_req ##1 o_handler_valid;
   endproperty
   a_go: assert property (p_go) else $error("handler late");
   property p_hold; o_slp_abort && i_prev_done |=> o_bus_req;
   endproperty
   a_hold: assert property (p_hold) else $error("fetch entry");
endmodule // swie_entry_chk
bind swie_entry swie_entry_chk u_chk (.i_sys_clk, .i_sys_rst, .i_irq,
   .i_prev_done, .i_sp, .i_vec_addr, .i_bus_ack, .o_sleeping, .o_slp_abort,
   .o_bus_req, .o_bus_we, .o_bus_addr, .o_handler_valid);

// *** verification/test_sleep_wakeup_interrupt_entry.sv ***
// Purpose: drives boundary, fetch, execute and sleep entries
// Assumes: i_ce tied high, bus partner acks late or slow
// Notes:   outputs sampled on the falling edge
`timescale 1ns/100ps
`include "swie_map.vh"
module test_sleep_wakeup_interrupt_entry;
   reg i_sys_clk = 0, i_sys_rst = 1, i_ce = 1, i_irq = 0, i_prev_done = 0;
   reg i_slp_fetch = 0, i_slp_exec = 0, i_slp_commit = 0, slow = 0;
   reg [23:0] i_slp_pc = 0, i_next_pc = 0, i_sp = 0, i_vec_addr = 0, eret;
   reg [7:0]  i_condition_flags_register = 0;
   reg [15:0] v1, v2;
   wire        i_bus_ack, o_sleeping, o_slp_abort, o_bus_req, o_bus_we;
   wire        o_handler_valid;
   wire [15:0] i_bus_rdata, o_bus_wdata;
   wire [23:0] o_bus_addr, o_ret_pc, o_handler_pc;
   integer bad_count = 0, total_checks = 0, seed = 32'h0d9fa24f, k, n;
   swie_entry dut (.i_sys_clk, .i_sys_rst, .i_ce, .i_irq, .i_prev_done,
      .i_slp_fetch, .i_slp_exec, .i_slp_commit, .i_slp_pc, .i_next_pc,
      .i_sp, .i_condition_flags_register, .i_vec_addr, .i_bus_ack,
      .i_bus_rdata, .o_sleeping, .o_slp_abort, .o_bus_req, .o_bus_we,
      .o_bus_addr, .o_bus_wdata, .o_ret_pc, .o_handler_pc, .o_handler_valid);
   swie_mem u_mem (.i_clk(i_sys_clk), .i_rst(i_sys_rst), .i_req(o_bus_req),
      .i_we(o_bus_we), .i_slow(slow), .i_addr(o_bus_addr),
      .i_wdata(o_bus_wdata), .o_ack(i_bus_ack), .o_rdata(i_bus_rdata));
   task chk(input string nm, input [23:0] e, input [23:0] s);
      total_checks = total_checks + 1;
      if (e !== s) begin
         bad_count = bad_count + 1;
         $display("wrong value %0s expected %h seen %h", nm, e, s);
      end
   endtask
   task conclude;
      if (bad_count == 0 && total_checks > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   // Kinds: 0 boundary, 1 during fetch, 2 early execute, 3 after sleep
   task run(input integer kind);
      reg slept;
      begin
         slept = 0;
         @(posedge i_sys_clk);
         i_slp_pc <= $random(seed);
         i_next_pc <= $random(seed);
         i_sp <= $random(seed) & 24'hfff000;
         i_vec_addr <= $random(seed) & 24'h0000fe;
         i_condition_flags_register <= $random(seed);
         slow <= $random(seed);
         v1 = $random(seed);
         v2 = $random(seed);
         @(posedge i_sys_clk);
         u_mem.mem[i_vec_addr] = v1;
         u_mem.mem[i_vec_addr + 24'h2] = v2;
         eret = (kind == 1) ? i_slp_pc : i_next_pc;
         if (kind == 3) begin
            i_slp_commit <= 1'b1;
            @(posedge i_sys_clk) i_slp_commit <= 1'b0;
            repeat (4) @(posedge i_sys_clk);
         end
         i_slp_fetch <= kind == 1;
         i_slp_exec <= kind == 2;
         i_prev_done <= !kind[0];
         i_irq <= 1'b1;
         n = 0;
         while (o_bus_req !== 1'b1 && n < 60) begin
            @(negedge i_sys_clk);
            n = n + 1;
            if (o_sleeping === 1'b1) slept = 1;
            if (n == 8 && kind == 1) begin
               chk("abort", 1, o_slp_abort);
               @(posedge i_sys_clk) i_prev_done <= 1'b1;
            end
         end
         chk("bus req", 1, o_bus_req);
         @(posedge i_sys_clk);
         i_irq <= 1'b0;
         i_slp_fetch <= 1'b0;
         i_slp_exec <= 1'b0;
         i_prev_done <= 1'b0;
         n = 0;
         while (o_handler_valid !== 1'b1 && n < 60) begin
            @(negedge i_sys_clk);
            n = n + 1;
         end
         chk("hvalid", 1, o_handler_valid);
         chk("slept", kind == 3, slept);
         chk("ret pc", eret, o_ret_pc);
         chk("handler", {v1[7:0], v2}, o_handler_pc);
         chk("push pc", eret[15:0], u_mem.mem[i_sp - 24'h2]);
         chk("push flg", {i_condition_flags_register, eret[23:16]},
             u_mem.mem[i_sp - 24'h4]);
      end
   endtask
   initial forever #2 i_sys_clk = ~i_sys_clk;
   // Watchdog: runs are a few hundred cycles at most
   initial begin
      #40000;
      bad_count = bad_count + 1;
      conclude;
   end
   initial begin
      repeat (10) @(posedge i_sys_clk);
      i_sys_rst <= 1'b0;
      for (k = 0; k < 8; k = k + 1) run(k % 4);
      conclude;
   end
endmodule // test_sleep_wakeup_interrupt_entry
